/* verilog/iss_sync_monitor.sv */
/*
  iss_sync_monitor: lock/sync indicators, pair alignment, channel status
  decode, madi rate policing and user bit embedding, with apb registers.
  assumes all inputs synchronous to REF_CLK and frame strobes one cycle long.
*/
// The APB slave port and the register offsets were left to the implementer.
// What this block does
// - locked aes input makes its indicator flash
// - locked and synchronous input holds indicator on
// - every clock compared; non-identical inputs flash
// - four aes pairs released sample aligned
// - status bit 0 selects professional/consumer layout
// - professional byte 0: audio, emphasis, locked, rate
// - consumer byte 0: audio, copy, emphasis, mode
// - 64-channel madi rate capped near 48k+1%, or twice that with the 96k mode bit set
// - 56-channel madi: 28 pairs, rate capped near 48k+12.5%
// - madi has one lock and sync state
// - midi and serial data hidden in user bits
`timescale 1ns/1ps
module iss_sync_monitor import iss_pkg::*; #(
  parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYCLES,
  parameter int unsigned WIN_FRAMES = WINDOW_FRAMES
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic MASTER_FRAME,
  input wire logic [N_AES-1:0] AES_LOCK,
  input wire logic [N_AES-1:0] AES_FRAME,
  input wire logic [N_AES-1:0] AES_CS_STB,
  input wire logic [N_AES*CS_W-1:0] AES_CS_BYTE,
  input wire logic MADI_LOCK,
  input wire logic MADI_FRAME,
  input wire logic [6:0] MADI_TX_CH,
  input wire logic MADI_TX_USER_IN,
  input wire logic MIDI_TX_BIT,
  input wire logic SERIAL_TX_BIT,
  output logic MADI_TX_USER,
  output logic [5:0] MADI_PAIR_COUNT,
  output logic [N_IN-1:0] SYNC_LED,
  output logic ALIGNED_FRAME,
  output logic IRQ
);
  localparam int unsigned WIN_W = $clog2(WIN_FRAMES + 1);
  localparam int unsigned BLK_W = $clog2(BLINK_CYCLES + 1);
  localparam int unsigned PER_W = 16;

  // user bit source for one madi channel slot
  function automatic logic embed_bit(input logic [6:0] ch, input logic hi_rate,
                                     input logic orig, input logic midi, input logic ser);
    logic [6:0] midi_ch;
    midi_ch = hi_rate ? MIDI_CH_96K : MIDI_CH_48K;
    if (ch == midi_ch) begin
      embed_bit = midi;
    end else if (ch >= SER_CH_FIRST && ch <= SER_CH_LAST) begin
      embed_bit = ser;
    end else begin
      embed_bit = orig;
    end
  endfunction : embed_bit

  // control and register state
  logic [CTRL_W-1:0] ctrl_ff; // align enable, madi mode bits, cs select
  logic [IRQ_W-1:0] irq_stat_ff; // sticky events
  logic [IRQ_W-1:0] irq_mask_ff; // event enables
  logic pready_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  // apb phase decode
  logic access; // first access cycle, answer is being prepared
  logic wr_now; // edge at which a write takes effect
  logic mapped; // address hits a register
  // input views: madi sits above the aes pairs
  logic [N_IN-1:0] lock_v;
  logic [N_IN-1:0] frame_v;
  logic [N_IN-1:0] sync_v; // per-input agreement with master
  logic [N_IN-1:0] lock_d_ff; // previous lock, for lost events
  logic [N_IN-1:0] sync_d_ff; // previous sync, for lost events
  // window and flash timing
  logic [WIN_W-1:0] win_cnt_ff;
  logic win_end;
  logic [BLK_W-1:0] blink_cnt_ff;
  logic blink_ff; // flash phase
  // alignment
  logic [N_AES-1:0] pend_ff; // pairs holding a sample not yet released
  logic [N_AES-1:0] have;
  logic release_now;
  logic slip_ev; // a pair got a whole sample ahead
  // madi rate policing
  logic [PER_W-1:0] madi_per_ff;
  logic madi_seen_ff;
  logic [PER_W-1:0] min_per;
  logic madi_rate_ev;
  // channel status capture
  logic [CS_W-1:0] cs_ff [N_AES];
  logic [CS_W-1:0] cs_sel;
  logic dec_pro, dec_audio, dec_locked, dec_copy;
  logic [2:0] dec_emph;
  logic [1:0] dec_fs;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] w1c;
  logic [31:0] nxt_prdata;
  logic out_aligned_ff, out_user_ff, irq_ff;
  logic [5:0] pairs_ff;
  logic [N_IN-1:0] led_ff;

  assign lock_v = {MADI_LOCK, AES_LOCK};
  assign frame_v = {MADI_FRAME, AES_FRAME};

  // master frame window; one window end feeds every comparator
  assign win_end = MASTER_FRAME && (win_cnt_ff == WIN_W'(WIN_FRAMES - 1));
  always_ff @(posedge REF_CLK) begin
    if (RESET || win_end) begin
      win_cnt_ff <= '0;
    end else if (MASTER_FRAME) begin
      win_cnt_ff <= win_cnt_ff + WIN_W'(1);
    end
  end

  // one comparator per input; madi gets a single one for all its channels
  for (genvar i = 0; i < N_IN; i++) begin : g_cmp
    iss_rate_cmp #(.CW(WIN_W)) u_cmp (
      .clk(REF_CLK),
      .rst(RESET),
      .lock(lock_v[i]),
      .frame(frame_v[i]),
      .win_end(win_end),
      .target(WIN_W'(WIN_FRAMES)),
      .sync_ff(sync_v[i])
    );
  end

  // flash divider: one-cycle enable toggles the flash phase
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      blink_cnt_ff <= '0;
      blink_ff <= 1'b0;
    end else if (blink_cnt_ff == BLK_W'(BLINK_CYCLES - 1)) begin
      blink_cnt_ff <= '0;
      blink_ff <= !blink_ff;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + BLK_W'(1);
    end
  end

  // indicators: dark unlocked, flashing locked, steady when in sync
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      led_ff <= '0;
    end else begin
      led_ff <= lock_v & (sync_v | {N_IN{blink_ff}});
    end
  end

  // alignment: hold each pair's sample until every locked pair has one
  assign have = (pend_ff | AES_FRAME) & AES_LOCK;
  assign release_now = (|AES_LOCK) && (have == AES_LOCK);
  assign slip_ev = |(AES_FRAME & pend_ff & AES_LOCK);
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pend_ff <= '0;
    end else if (release_now) begin
      // a pair already pending that delivers again stays one ahead
      pend_ff <= AES_FRAME & pend_ff & AES_LOCK;
    end else begin
      pend_ff <= have;
    end
  end

  // aligned strobe; bypass follows the first pair alone
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      out_aligned_ff <= 1'b0;
    end else begin
      out_aligned_ff <= ctrl_ff[CTRL_ALIGN_EN] ? release_now : AES_FRAME[0];
    end
  end

  // madi frame period; too short means the mode's rate cap is exceeded
  always_comb begin
    if (!ctrl_ff[CTRL_MADI64]) begin
      min_per = PER_W'(MADI56_MIN_CYC);
    end else if (ctrl_ff[CTRL_MADI96]) begin
      min_per = PER_W'(MADI64_MIN_CYC / 2);
    end else begin
      min_per = PER_W'(MADI64_MIN_CYC);
    end
  end
  assign madi_rate_ev = MADI_FRAME && madi_seen_ff && (madi_per_ff < min_per);
  always_ff @(posedge REF_CLK) begin
    if (RESET || !MADI_LOCK) begin
      madi_per_ff <= '0;
      madi_seen_ff <= 1'b0;
    end else if (MADI_FRAME) begin
      madi_per_ff <= PER_W'(1);
      madi_seen_ff <= 1'b1;
    end else if (madi_per_ff != '1) begin
      madi_per_ff <= madi_per_ff + PER_W'(1); // saturates, slow rates are fine
    end
  end

  // pairs carried per madi frame for the selected mode
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pairs_ff <= MADI56_PAIRS;
    end else begin
      pairs_ff <= ctrl_ff[CTRL_MADI64] ? MADI64_PAIRS : MADI56_PAIRS;
    end
  end

  // user bit embedding; audio bits are never touched, so receivers stay happy
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      out_user_ff <= 1'b0;
    end else begin
      out_user_ff <= embed_bit(MADI_TX_CH, ctrl_ff[CTRL_MADI96], MADI_TX_USER_IN,
                               MIDI_TX_BIT, SERIAL_TX_BIT);
    end
  end

  // channel status byte 0 per pair
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      for (int i = 0; i < N_AES; i++) begin
        cs_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N_AES; i++) begin
        if (AES_CS_STB[i]) begin
          cs_ff[i] <= AES_CS_BYTE[i*CS_W +: CS_W];
        end
      end
    end
  end
  assign cs_sel = cs_ff[ctrl_ff[CTRL_CSSEL_LO +: 2]];

  iss_cs_decode u_dec (
    .cs_byte(cs_sel),
    .pro(dec_pro),
    .audio(dec_audio),
    .emph(dec_emph),
    .locked(dec_locked),
    .copy(dec_copy),
    .fs_mode(dec_fs)
  );

  // previous lock and sync, to spot losses
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      lock_d_ff <= '0;
      sync_d_ff <= '0;
    end else begin
      lock_d_ff <= lock_v;
      sync_d_ff <= sync_v;
    end
  end
  assign events = {madi_rate_ev, slip_ev, sync_d_ff & ~sync_v, lock_d_ff & ~lock_v};

  // apb: one wait state, answer stands in the second access cycle
  assign access = PSEL && PENABLE && !pready_ff;
  assign wr_now = PSEL && PENABLE && pready_ff && PWRITE;
  assign mapped = (PADDR == ADDR_CTRL) || (PADDR == ADDR_LIVE) || (PADDR == ADDR_CS_DEC) ||
                  (PADDR == ADDR_IRQ_STAT) || (PADDR == ADDR_IRQ_MASK);
  assign w1c = (wr_now && PADDR == ADDR_IRQ_STAT) ? PWDATA[IRQ_W-1:0] : '0;

  // read mux
  always_comb begin
    nxt_prdata = '0;
    case (PADDR)
      ADDR_CTRL: nxt_prdata = {24'h000000, ctrl_ff};
      ADDR_LIVE: nxt_prdata = {10'h000, pairs_ff, 3'h0, sync_v, 3'h0, lock_v};
      ADDR_CS_DEC: nxt_prdata = {15'h0000, dec_copy, dec_fs, dec_locked, dec_emph,
                                 dec_audio, dec_pro, cs_sel};
      ADDR_IRQ_STAT: nxt_prdata = {20'h00000, irq_stat_ff};
      ADDR_IRQ_MASK: nxt_prdata = {20'h00000, irq_mask_ff};
      default: nxt_prdata = '0;
    endcase
  end

  // bus handshake and answer registers
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pready_ff <= 1'b0;
      prdata_ff <= '0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= access;
      pslverr_ff <= access && !mapped;
      if (access && !PWRITE) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // software control registers
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ctrl_ff <= CTRL_RESET;
      irq_mask_ff <= '0;
    end else if (wr_now && PADDR == ADDR_CTRL) begin
      ctrl_ff <= PWDATA[CTRL_W-1:0] & CTRL_WMASK;
    end else if (wr_now && PADDR == ADDR_IRQ_MASK) begin
      irq_mask_ff <= PWDATA[IRQ_W-1:0];
    end
  end

  // sticky events; a new event beats a same-cycle clear
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~w1c) | events;
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign SYNC_LED = led_ff;
  assign ALIGNED_FRAME = out_aligned_ff;
  assign MADI_TX_USER = out_user_ff;
  assign MADI_PAIR_COUNT = pairs_ff;
  assign IRQ = irq_ff;

  a_led_dark_unlock: assert property (@(posedge REF_CLK) disable iff (RESET)
    !AES_LOCK[0] |=> !SYNC_LED[0])
    else $error("indicator lit on an unlocked input");
  a_led_flash_phase: assert property (@(posedge REF_CLK) disable iff (RESET)
    AES_LOCK[1] && !sync_v[1] |=> SYNC_LED[1] == $past(blink_ff))
    else $error("locked asynchronous input not flashing");
  a_led_steady_sync: assert property (@(posedge REF_CLK) disable iff (RESET)
    (AES_LOCK[2] && sync_v[2]) [*2] |=> SYNC_LED[2])
    else $error("synchronous input indicator not steady");
  a_madi_led_single: assert property (@(posedge REF_CLK) disable iff (RESET)
    MADI_LOCK && sync_v[N_IN-1] |=> SYNC_LED[N_IN-1])
    else $error("madi indicator off while locked and in sync");
  a_async_flashes: assert property (@(posedge REF_CLK) disable iff (RESET)
    lock_v[3] && !sync_v[3] && !blink_ff |=> !SYNC_LED[3])
    else $error("asynchronous input shown steady");
  a_align_all_pairs: assert property (@(posedge REF_CLK) disable iff (RESET)
    $past(ctrl_ff[CTRL_ALIGN_EN]) && ALIGNED_FRAME |->
    $past(have) == $past(AES_LOCK) && $past(|AES_LOCK))
    else $error("aligned strobe before every locked pair had a sample");
  a_align_clears: assert property (@(posedge REF_CLK) disable iff (RESET)
    release_now && !slip_ev |=> pend_ff == '0)
    else $error("pending samples kept after release");
  a_pro_layout: assert property (@(posedge REF_CLK) disable iff (RESET)
    cs_sel[CS_PC_BIT] |-> dec_pro && dec_emph == cs_sel[PRO_EMPH_LO +: 3] && !dec_copy)
    else $error("professional byte decoded with consumer layout");
  a_con_layout: assert property (@(posedge REF_CLK) disable iff (RESET)
    !cs_sel[CS_PC_BIT] |-> !dec_pro && dec_copy == cs_sel[CON_COPY_BIT] && !dec_locked)
    else $error("consumer byte decoded with professional layout");
  a_madi64_rate: assert property (@(posedge REF_CLK) disable iff (RESET)
    MADI_LOCK && MADI_FRAME && madi_seen_ff && ctrl_ff[CTRL_MADI64] && !ctrl_ff[CTRL_MADI96] &&
    madi_per_ff < PER_W'(MADI64_MIN_CYC) |=> irq_stat_ff[IRQ_W-1])
    else $error("64-channel madi over-rate not flagged");
  a_madi56_pairs: assert property (@(posedge REF_CLK) disable iff (RESET)
    !ctrl_ff[CTRL_MADI64] |=> MADI_PAIR_COUNT == MADI56_PAIRS)
    else $error("56-channel madi pair count wrong");
  a_user_midi: assert property (@(posedge REF_CLK) disable iff (RESET)
    !ctrl_ff[CTRL_MADI96] && MADI_TX_CH == MIDI_CH_48K |=> MADI_TX_USER == $past(MIDI_TX_BIT))
    else $error("midi bit not placed in its user slot");
  a_irq_level: assert property (@(posedge REF_CLK) disable iff (RESET)
    IRQ == $past(|(irq_stat_ff & irq_mask_ff)))
    else $error("interrupt output disagrees with masked status");
endmodule : iss_sync_monitor

/* verilog/iss_pkg.sv */
/*
  iss_pkg: constants shared by the input sync status monitor.
  assumes a single 125 MHz reference clock and a 32-bit apb register bus.
*/
package iss_pkg;
  // clock
  localparam int unsigned CLK_PERIOD_NS = 8;
  // input counts: four aes pairs plus one madi port
  localparam int unsigned N_AES = 4;
  localparam int unsigned N_IN = 5;
  localparam int unsigned CS_W = 8;
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_LIVE = 12'h004;
  localparam logic [11:0] ADDR_CS_DEC = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
  // control fields
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned CTRL_ALIGN_EN = 0;
  localparam int unsigned CTRL_MADI64 = 1;
  localparam int unsigned CTRL_MADI96 = 2;
  localparam int unsigned CTRL_CSSEL_LO = 4;
  localparam logic [7:0] CTRL_RESET = 8'h03;
  localparam logic [7:0] CTRL_WMASK = 8'h37;
  // channel status byte 0 fields
  localparam int unsigned CS_PC_BIT = 0;
  localparam int unsigned CS_AUDIO_BIT = 1;
  localparam int unsigned PRO_EMPH_LO = 2;
  localparam int unsigned PRO_LOCK_BIT = 5;
  localparam int unsigned PRO_FS_LO = 6;
  localparam int unsigned CON_COPY_BIT = 2;
  localparam int unsigned CON_EMPH_LO = 3;
  localparam int unsigned CON_MODE_LO = 6;
  // interrupt status width: lock lost x5, sync lost x5, slip, madi rate
  localparam int unsigned IRQ_W = 12;
  // madi framing limits
  localparam int unsigned MADI64_MAX_HZ = 48480;
  localparam int unsigned MADI56_MAX_HZ = 54000;
  localparam int unsigned MADI64_MIN_PER_NS = (1000000000 + MADI64_MAX_HZ - 1) / MADI64_MAX_HZ;
  localparam int unsigned MADI56_MIN_PER_NS = (1000000000 + MADI56_MAX_HZ - 1) / MADI56_MAX_HZ;
  localparam int unsigned MADI64_MIN_CYC = (MADI64_MIN_PER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MADI56_MIN_CYC = (MADI56_MIN_PER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] MADI56_PAIRS = 6'h1C;
  localparam logic [5:0] MADI64_PAIRS = 6'h20;
  // user bit channels (numbered from one) carrying midi and serial data
  localparam logic [6:0] MIDI_CH_48K = 7'h38;
  localparam logic [6:0] MIDI_CH_96K = 7'h1C;
  localparam logic [6:0] SER_CH_FIRST = 7'h01;
  localparam logic [6:0] SER_CH_LAST = 7'h09;
  // indicator flash half period and sync window
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned WINDOW_FRAMES = 64;
endpackage : iss_pkg

/* verilog/iss_rate_cmp.sv */
/*
  iss_rate_cmp: counts one input's frames over a window of master frames.
  assumes frame and win_end are single-cycle pulses on clk.
*/
`timescale 1ns/1ps
module iss_rate_cmp import iss_pkg::*; #(
  parameter int unsigned CW = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic lock,
  input wire logic frame,
  input wire logic win_end,
  input wire logic [CW-1:0] target,
  output logic sync_ff
);
  logic [CW-1:0] cnt_ff; // frames seen in the current window
  logic [CW-1:0] total; // count including a frame on the closing edge

  assign total = cnt_ff + {{(CW-1){1'b0}}, frame};

  // window frame counter, restarted at each window end
  always_ff @(posedge clk) begin
    if (rst || !lock) begin
      cnt_ff <= '0;
    end else if (win_end) begin
      cnt_ff <= '0;
    end else if (frame) begin
      cnt_ff <= total;
    end
  end

  // any count difference marks the input asynchronous
  always_ff @(posedge clk) begin
    if (rst || !lock) begin
      sync_ff <= 1'b0;
    end else if (win_end) begin
      sync_ff <= (total == target);
    end
  end

  a_sync_count: assert property (@(posedge clk) disable iff (rst)
    lock && win_end && (total != target) |=> !sync_ff)
    else $error("sync held despite frame count mismatch");
endmodule : iss_rate_cmp

/* verilog/iss_cs_decode.sv */
/*
  iss_cs_decode: splits channel status byte 0 by professional/consumer layout.
  assumes the byte was captured whole; purely combinational.
*/
`timescale 1ns/1ps
module iss_cs_decode import iss_pkg::*; (
  input wire logic [CS_W-1:0] cs_byte,
  output logic pro,
  output logic audio,
  output logic [2:0] emph,
  output logic locked,
  output logic copy,
  output logic [1:0] fs_mode
);
  // bit 0 picks the layout for bits 2 to 7; bit 1 is audio in both
  always_comb begin
    pro = cs_byte[CS_PC_BIT];
    audio = cs_byte[CS_AUDIO_BIT];
    if (pro) begin
      emph = cs_byte[PRO_EMPH_LO +: 3];
      locked = cs_byte[PRO_LOCK_BIT];
      copy = 1'b0;
      fs_mode = cs_byte[PRO_FS_LO +: 2];
    end else begin
      // consumer layout shifts emphasis up past the copy bit
      emph = cs_byte[CON_EMPH_LO +: 3];
      locked = 1'b0;
      copy = cs_byte[CON_COPY_BIT];
      fs_mode = cs_byte[CON_MODE_LO +: 2];
    end
  end
endmodule : iss_cs_decode

/* sim/iss_src_model.sv */
/*
  iss_src_model: far-side audio sources, four aes pairs and one madi port.
  assumes per and ph only change around a restart pulse.
*/
`timescale 1ns/1ps
module iss_src_model import iss_pkg::*; (
  input wire logic clk,
  input wire logic restart,
  input wire logic [N_IN-1:0] lock_en,
  input wire logic [N_IN*12-1:0] per,
  input wire logic [N_IN*12-1:0] ph,
  output logic [N_IN-1:0] lock,
  output logic [N_IN-1:0] frame
);
  logic [11:0] cnt_ff [N_IN]; // per-source frame counters
  // each source ticks at its own rate; an unlocked source sends no frames
  always_ff @(posedge clk) begin
    for (int i = 0; i < N_IN; i++) begin
      lock[i] <= lock_en[i];
      if (restart) begin
        cnt_ff[i] <= ph[i*12+:12];
        frame[i] <= 1'h0;
      end else begin
        // period is whatever the bench asks, so rate limits can be broken on purpose
        cnt_ff[i] <= (cnt_ff[i] == per[i*12+:12] - 12'h001) ? 12'h000 : cnt_ff[i] + 12'h001;
        frame[i] <= lock_en[i] && cnt_ff[i] == per[i*12+:12] - 12'h001;
      end
    end
  end
endmodule : iss_src_model

/* sim/test_input_sync_status_monitor.sv */
/*
  test_input_sync_status_monitor: self-checking bench for the sync monitor.
  assumes iss_src_model as far side and shortened blink and window counts.
*/
`timescale 1ns/1ps
module test_input_sync_status_monitor import iss_pkg::*; ;
  // decode rows: pair, status byte, expected decode word
  typedef struct {logic [1:0] p; logic [7:0] b; logic [31:0] e;} iss_cs_row_t;
  // madi rows: control, frame period, over-rate flag, pair count
  typedef struct {logic [31:0] c; logic [11:0] per; logic o; logic [5:0] n;} iss_rate_row_t;
  iss_cs_row_t cs_rows [6] = '{'{2'h0, 8'h01, 32'h101}, '{2'h1, 8'h00, 32'h0}, '{2'h2, 8'hFF, 32'hFFFF},
    '{2'h3, 8'hFE, 32'h1DEFE}, '{2'h0, 8'h35, 32'h3535}, '{2'h2, 8'h2C, 32'h1142C}};
  iss_rate_row_t rate_rows [6] = '{'{32'h3, 12'hA28, 1'h0, 6'h20}, '{32'h3, 12'hA0A, 1'h1, 6'h20},
    '{32'h7, 12'h514, 1'h0, 6'h20}, '{32'h7, 12'h500, 1'h1, 6'h20}, '{32'h1, 12'h910, 1'h0, 6'h1C},
    '{32'h1, 12'h8FC, 1'h1, 6'h1C}};
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0; // apb master side
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, mframe = 1'h0, restart = 1'h1; // restart realigns every source
  logic [3:0] cs_stb = 4'h0;
  logic [31:0] cs_byte = 32'h0;
  logic [6:0] tx_ch = 7'h01;
  logic user_in = 1'h0, midi = 1'h0, ser = 1'h0, tx_user, aligned, irq, e;
  logic f0_q = 1'h0, f3_q = 1'h0, sel = 1'h0, on = 1'h0; // monitor state
  logic [5:0] pairs;
  logic [4:0] led, lock, frame, lock_en = 5'h0;
  logic [59:0] per = {5{12'h014}}, ph = 60'h0;
  logic [11:0] mcnt = 12'h0;
  int err_count = 0, cmp_count = 0, na = 0, nm = 0, n;
  // 125 MHz reference
  always #4 clk = ~clk;
  // device master frames, 20 cycles apart, restarted with the sources
  always @(posedge clk) begin
    mcnt <= (restart || mcnt == 12'h013) ? 12'h000 : mcnt + 12'h001;
    mframe <= !restart && mcnt == 12'h013;
  end
  // counts releases, and those one cycle after the chosen pair's sample
  always @(posedge clk) begin
    f0_q <= frame[0];
    f3_q <= frame[3];
    if (on) begin
      na += int'(aligned);
      nm += int'(aligned && (sel ? f0_q : f3_q));
    end
  end
  iss_src_model i_src (.clk(clk), .restart(restart), .lock_en(lock_en), .per(per), .ph(ph), .lock(lock),
    .frame(frame));
  // short blink and window keep the run brief
  iss_sync_monitor #(.BLINK_CYCLES(4), .WIN_FRAMES(4)) i_dut (.REF_CLK(clk), .RESET(rst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MASTER_FRAME(mframe), .AES_LOCK(lock[3:0]), .AES_FRAME(frame[3:0]),
    .AES_CS_STB(cs_stb), .AES_CS_BYTE(cs_byte), .MADI_LOCK(lock[4]), .MADI_FRAME(frame[4]),
    .MADI_TX_CH(tx_ch), .MADI_TX_USER_IN(user_in), .MIDI_TX_BIT(midi), .SERIAL_TX_BIT(ser),
    .MADI_TX_USER(tx_user), .MADI_PAIR_COUNT(pairs), .SYNC_LED(led), .ALIGNED_FRAME(aligned), .IRQ(irq));
  // one compare, counted; four-state equality so unknowns fail
  task automatic chk(input string nm_s, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm_s, x, g);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    if (pready !== 1'h1) begin
      chk("apb ready", 32'h1, 32'h0);
      give_verdict();
    end
  endtask : apb
  task automatic restart_src;
    @(posedge clk);
    restart <= 1'h1;
    @(posedge clk);
    restart <= 1'h0;
  endtask : restart_src
  initial begin
    // reset values, then control access kinds and a refused address
    repeat (3) @(posedge clk);
    chk("pairs in reset", 32'h1C, {26'h0, pairs});
    chk("leds in reset", 32'h0, {27'h0, led});
    chk("outs in reset", 32'h0, {28'h0, irq, aligned, tx_user, pready});
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    restart <= 1'h0;
    apb(1'h1, 12'h018, 32'hFFFFFFFF);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h3, rd);
    apb(1'h0, ADDR_IRQ_MASK, 32'h0);
    chk("mask reset", 32'h0, rd);
    apb(1'h1, ADDR_CTRL, 32'hFFFFFFFF);
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk("ctrl bits", 32'h37, rd);
    $display("test reset done");
    // decode rows, each through the selected pair
    foreach (cs_rows[i]) begin
      @(posedge clk);
      cs_byte <= {4{cs_rows[i].b}};
      cs_stb <= 4'h1 << cs_rows[i].p;
      @(posedge clk);
      cs_stb <= 4'h0;
      apb(1'h1, ADDR_CTRL, {26'h0, cs_rows[i].p, 4'h3});
      apb(1'h0, ADDR_CS_DEC, 32'h0);
      chk("cs decode", cs_rows[i].e, rd);
    end
    $display("test decode done");
    // user bits: passthrough, midi slot, serial slots, 96k midi slot
    for (int m = 0; m < 3; m++) begin
      apb(1'h1, ADDR_CTRL, (m == 2) ? 32'h7 : 32'h3);
      for (int c = 1; c <= 64; c++) begin
        @(posedge clk);
        tx_ch <= 7'(c);
        user_in <= (m == 0);
        midi <= (m != 0);
        ser <= (m == 2);
        e = (c <= 9) ? (m == 2) : (c == ((m == 2) ? 28 : 56)) ? (m != 0) : (m == 0);
        @(posedge clk);
        @(negedge clk);
        chk("user bit", {31'h0, e}, {31'h0, tx_user});
      end
    end
    $display("test embed done");
    // aes0 and madi at master rate, aes1 foreign, aes2 and aes3 silent
    apb(1'h1, ADDR_CTRL, 32'h3);
    per <= {12'h014, 12'h014, 12'h014, 12'h01E, 12'h014};
    lock_en <= 5'h13;
    restart_src();
    repeat (400) @(posedge clk);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      n += int'(led[1]);
      chk("steady leds", 32'h11, {27'h0, led & 5'h1D});
    end
    chk("aes1 flashing", 32'h1, {31'h0, n > 0 && n < 40});
    apb(1'h0, ADDR_LIVE, 32'h0);
    chk("live state", 32'h201113, rd);
    apb(1'h0, ADDR_IRQ_STAT, 32'h0);
    chk("slip and rate", 32'hC00, rd & 32'hC00);
    // interrupt: clear, raise while masked, unmask, clear
    lock_en <= 5'h01;
    repeat (20) @(posedge clk);
    apb(1'h1, ADDR_IRQ_STAT, 32'hFFF);
    apb(1'h0, ADDR_IRQ_STAT, 32'h0);
    chk("status clear", 32'h0, rd);
    lock_en <= 5'h00;
    repeat (5) @(posedge clk);
    apb(1'h0, ADDR_IRQ_STAT, 32'h0);
    chk("lock lost", 32'h1, rd & 32'h1);
    chk("masked irq", 32'h0, {31'h0, irq});
    chk("leds dark", 32'h0, {27'h0, led});
    apb(1'h1, ADDR_IRQ_MASK, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'h1, ADDR_IRQ_STAT, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test sync done");
    // four pairs skewed; release follows the latest pair, or pair 0 when off
    apb(1'h1, ADDR_IRQ_MASK, 32'h0);
    per <= {5{12'h014}};
    ph <= {12'h0, 12'h0, 12'h3, 12'h7, 12'hB};
    lock_en <= 5'h0F;
    restart_src();
    for (int s = 0; s < 2; s++) begin
      apb(1'h1, ADDR_CTRL, s ? 32'h2 : 32'h3);
      repeat (100) @(posedge clk);
      apb(1'h1, ADDR_IRQ_STAT, 32'hFFF);
      sel <= s[0];
      na = 0;
      nm = 0;
      on <= 1'h1;
      repeat (400) @(posedge clk);
      on <= 1'h0;
      @(negedge clk);
      chk("release count", 32'h14, na);
      chk("release timing", 32'h14, nm);
      apb(1'h0, ADDR_IRQ_STAT, 32'h0);
      chk("no slip", 32'h0, rd & 32'h400);
    end
    $display("test align done");
    // madi frame periods each side of every mode's limit
    lock_en <= 5'h10;
    foreach (rate_rows[i]) begin
      apb(1'h1, ADDR_CTRL, rate_rows[i].c);
      per <= {rate_rows[i].per, 48'h0};
      restart_src();
      repeat (2 * rate_rows[i].per) @(posedge clk);
      apb(1'h1, ADDR_IRQ_STAT, 32'hFFF);
      repeat (2 * rate_rows[i].per) @(posedge clk);
      apb(1'h0, ADDR_IRQ_STAT, 32'h0);
      chk("madi over rate", {20'h0, rate_rows[i].o, 11'h0}, rd & 32'h800);
      chk("madi pairs", {26'h0, rate_rows[i].n}, {26'h0, pairs});
    end
    $display("test madi done");
    give_verdict();
  end
endmodule : test_input_sync_status_monitor
